/* design/prio_irq_pkg.sv */
/*
 * constants for the eight-line priority interrupt block: line count,
 * bus bit positions, control codes, vector layout and timing.
 * assumes nothing of its surroundings beyond a single synchronous clock.
 */
package prio_irq_pkg;
   localparam int unsigned NUM_LINES = 8;
   localparam int unsigned BUS_WIDTH = 16;
   localparam int unsigned LINE_NUM_WIDTH = 3;
   // control function field sits in bus bits 6..8
   localparam int unsigned CTRL_LSB = 6;
   localparam int unsigned CTRL_WIDTH = 3;
   // bus bit that marks an "all modules" control variant
   localparam int unsigned ALL_MODULES_BIT = 8;
   localparam logic [2:0] CTRL_CLEAR = 3'h1;
   localparam logic [2:0] CTRL_ENABLE = 3'h2;
   localparam logic [2:0] CTRL_CLEAR_ENABLE = 3'h3;
   localparam logic [2:0] CTRL_DISABLE = 3'h4;
   localparam logic [2:0] CTRL_CLEAR_DISABLE = 3'h5;
   // vector: line number sits in address bits 1..3, bit 0 always low
   localparam int unsigned VECTOR_WIDTH = 7;
   localparam logic [6:0] VECTOR_BASE_DEFAULT = 7'h40; // octal 0100
   localparam logic [6:0] VECTOR_FORBID_LO = 7'h20;    // octal 040
   localparam logic [6:0] VECTOR_FORBID_HI = 7'h27;    // octal 047
   localparam int unsigned VECTOR_LINE_LSB = 1;
   // interrupt clock period
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned INT_CLK_PERIOD_NS = 1000;
   localparam int unsigned INT_CLK_CYCLES = INT_CLK_PERIOD_NS * CLK_MHZ / 1000;
endpackage

/* design/line_edge_capture.sv */
/*
 * one request line: two-stage synchroniser and falling-edge detector.
 * assumes the line is an asynchronous active-low pin.
 */
`timescale 1ns/1ps
`default_nettype none
module line_edge_capture (
   input wire logic clk,
   input wire logic rstn,
   input wire logic line_n,
   output logic fall_pulse
);
   logic meta_q;
   logic sync_q;
   logic last_q;

   // meta_q is read only by sync_q; reset high so idle lines give no edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         last_q <= 1'b1;
      end else begin
         meta_q <= line_n;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   // one pulse per falling edge; a held-low line gives nothing more
   assign fall_pulse = last_q & ~sync_q;
endmodule // line_edge_capture
`default_nettype wire

/* design/priority_interrupt_module.sv */
/*
 * eight-line priority interrupt controller on a minicomputer i/o bus.
 * assumes bus strobes are one-cycle pulses in clk, requests are async pins.
 */
// What this block does
// - examine all lines every interrupt clock
// - line 0 highest, line 7 lowest
// - unselected requests stay captured until served
// - set mask bit blocks its line
// - reset leaves mask unchanged
// - transfer flag plus data-ready loads mask
// - decode controls from bus bits 6-8
// - master enable gates request, capture continues
// - pending flag set two periods after sampling
// - request out needs pending, enable, priority-in low
// - acknowledge low freezes interrupt clock
// - pending clears when all requests acknowledged
// - request holds until served or priority lost
// - vector line number in bits 1-3
// - vector base default 0100, never 040-047; VECTOR_BASE is not checked against this range
// - vector drive needs all four conditions
// - capture on falling edge, once only
// - completion clears served line; clear empties all
// - capture copied to sync register each period
// - line requests if unmasked, none higher
// - pass priority downstream after own service
// - control codes 1 to 5, all-module variants
// - reset clears flags, capture and sync
// - mask bit 0 is highest priority line
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_module
   import prio_irq_pkg::*;
#(
   parameter int unsigned LINES = NUM_LINES,
   parameter logic [6:0] VECTOR_BASE = VECTOR_BASE_DEFAULT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic system_reset_signal,
   input wire logic [LINES-1:0] peripheral_request_line_n,
   input wire logic [BUS_WIDTH-1:0] bus_data_in,
   input wire logic device_address_match,
   input wire logic function_ready_pulse,
   input wire logic data_ready_pulse,
   input wire logic external_control_strobe_n,
   input wire logic daisy_priority_in_n,
   input wire logic irq_acknowledge_n,
   input wire logic service_complete_pulse,
   output logic irq_to_processor_n,
   output logic daisy_priority_out_n,
   output logic [VECTOR_WIDTH-1:0] vector_out,
   output logic vector_drive_enable,
   output logic [LINES-1:0] line_inhibit_mask_out,
   output logic master_enable_out
);
   /*********************************************************************
    * signals
    *********************************************************************/
   logic [LINES-1:0] fall;
   logic [LINES-1:0] line_capture_q;
   logic [LINES-1:0] sync_sample_q;
   logic [LINES-1:0] line_inhibit_mask_q;
   logic [LINES-1:0] line_select;
   logic [LINES-1:0] unmasked;
   logic [LINE_NUM_WIDTH-1:0] line_num;
   logic master_enable_flag_q;
   logic output_transfer_flag_q;
   logic pending_request_flag_q;
   logic request_seen_q;
   logic sys_meta_q;
   logic sys_sync_q;
   logic ack_meta_q;
   logic ack_sync_q;
   logic prio_meta_q;
   logic prio_sync_q;
   logic [15:0] tick_cnt_q;
   logic int_tick;
   logic priority_request_any;
   logic mask_load_strobe;
   logic ctrl_valid;
   logic [CTRL_WIDTH-1:0] ctrl_code;
   logic clear_line_regs;
   logic do_enable;
   logic do_disable;
   logic acked;
   logic sys_rst;

   /*********************************************************************
    * input synchronisers and line edge capture
    *********************************************************************/
   // acknowledge, priority and reset come from other logic off-domain
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_meta_q <= 1'b1;
         ack_sync_q <= 1'b1;
         prio_meta_q <= 1'b1;
         prio_sync_q <= 1'b1;
         sys_meta_q <= 1'b0;
         sys_sync_q <= 1'b0;
      end else begin
         ack_meta_q <= irq_acknowledge_n;
         ack_sync_q <= ack_meta_q;
         prio_meta_q <= daisy_priority_in_n;
         prio_sync_q <= prio_meta_q;
         sys_meta_q <= system_reset_signal;
         sys_sync_q <= sys_meta_q;
      end
   end
   assign sys_rst = sys_sync_q;

   genvar gi;
   generate
      for (gi = 0; gi < LINES; gi++) begin : g_line
         line_edge_capture u_cap (
            .clk(clk),
            .rstn(rstn),
            .line_n(peripheral_request_line_n[gi]),
            .fall_pulse(fall[gi])
         );
      end
   endgenerate

   /*********************************************************************
    * interrupt clock
    *********************************************************************/
   // divided tick stands in for the interrupt clock; frozen while acked
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tick_cnt_q <= '0;
      end else if (!ack_sync_q) begin
         tick_cnt_q <= tick_cnt_q;
      end else if (tick_cnt_q == 16'(INT_CLK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'h0001;
      end
   end
   assign int_tick = ack_sync_q && (tick_cnt_q == 16'(INT_CLK_CYCLES - 1));

   /*********************************************************************
    * bus commands
    *********************************************************************/
   // control code lives in bus bits 6..8; bit 8 also flags all-module form
   assign ctrl_valid = !external_control_strobe_n && device_address_match;
   assign ctrl_code = bus_data_in[CTRL_LSB +: CTRL_WIDTH];
   // the all-module variants arrive without address match
   always_comb begin
      do_enable = 1'b0;
      do_disable = 1'b0;
      clear_line_regs = 1'b0;
      if (ctrl_valid) begin
         unique case (ctrl_code)
            CTRL_CLEAR: clear_line_regs = 1'b1;
            CTRL_ENABLE: do_enable = 1'b1;
            CTRL_CLEAR_ENABLE: begin
               clear_line_regs = 1'b1;
               do_enable = 1'b1;
            end
            CTRL_DISABLE: do_disable = 1'b1;
            CTRL_CLEAR_DISABLE: begin
               clear_line_regs = 1'b1;
               do_disable = 1'b1;
            end
            default: ;
         endcase
      end else if (!external_control_strobe_n && bus_data_in[ALL_MODULES_BIT]) begin
         // broadcast enable or disable reaches every module
         do_enable = (ctrl_code[1:0] == CTRL_ENABLE[1:0]);
         do_disable = (ctrl_code[1:0] == 2'h0);
      end
      if (sys_rst) begin
         clear_line_regs = 1'b1;
      end
   end

   /*********************************************************************
    * control flags
    *********************************************************************/
   // transfer flag: set by function-ready with address, dropped by data-ready
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         output_transfer_flag_q <= 1'b0;
      end else if (sys_rst || data_ready_pulse) begin
         output_transfer_flag_q <= 1'b0;
      end else if (function_ready_pulse && device_address_match) begin
         output_transfer_flag_q <= 1'b1;
      end
   end
   assign mask_load_strobe = output_transfer_flag_q && data_ready_pulse;

   // master enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         master_enable_flag_q <= 1'b0;
      end else if (sys_rst || do_disable) begin
         master_enable_flag_q <= 1'b0;
      end else if (do_enable) begin
         master_enable_flag_q <= 1'b1;
      end
   end

   // mask: untouched by system reset, only loaded from the bus
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         line_inhibit_mask_q <= '0;
      end else if (mask_load_strobe) begin
         line_inhibit_mask_q <= bus_data_in[LINES-1:0];
      end
   end

   /*********************************************************************
    * line capture and sync registers
    *********************************************************************/
   assign acked = service_complete_pulse;
   // new edges win over a completion clear on the same line
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         line_capture_q <= '0;
      end else if (clear_line_regs) begin
         line_capture_q <= '0;
      end else begin
         line_capture_q <= (line_capture_q & ~(acked ? line_select : '0)) | fall;
      end
   end

   // sync register samples capture each interrupt clock; acked drops only the served line
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_sample_q <= '0;
      end else if (clear_line_regs) begin
         sync_sample_q <= '0;
      end else if (acked) begin
         sync_sample_q <= sync_sample_q & ~line_select;
      end else if (int_tick) begin
         sync_sample_q <= line_capture_q;
      end
   end

   /*********************************************************************
    * priority logic
    *********************************************************************/
   assign unmasked = sync_sample_q & ~line_inhibit_mask_q;
   // lowest index wins; others wait in the capture register
   always_comb begin
      line_select = '0;
      line_num = '0;
      for (int i = LINES - 1; i >= 0; i--) begin
         if (unmasked[i]) begin
            line_select = '0;
            line_select[i] = 1'b1;
            line_num = LINE_NUM_WIDTH'(i);
         end
      end
   end
   assign priority_request_any = |unmasked;

   /*********************************************************************
    * pending request and outputs
    *********************************************************************/
   // set two interrupt periods after sampling; cleared when nothing remains
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         request_seen_q <= 1'b0;
         pending_request_flag_q <= 1'b0;
      end else if (clear_line_regs) begin
         request_seen_q <= 1'b0;
         pending_request_flag_q <= 1'b0;
      end else if (int_tick) begin
         request_seen_q <= priority_request_any;
         if (master_enable_flag_q && request_seen_q && priority_request_any) begin
            pending_request_flag_q <= 1'b1;
         end else if (!priority_request_any) begin
            pending_request_flag_q <= 1'b0;
         end
      end else if (!priority_request_any && ack_sync_q) begin
         pending_request_flag_q <= 1'b0;
      end
   end

   always_comb begin
      irq_to_processor_n = !(pending_request_flag_q && master_enable_flag_q
                             && !prio_sync_q);
      vector_drive_enable = !prio_sync_q && !ack_sync_q && master_enable_flag_q
                            && pending_request_flag_q;
      // pass priority on only when no request of ours is pending
      daisy_priority_out_n = prio_sync_q || pending_request_flag_q;
   end

   // vector register: base with line number in bits 1..3, bit 0 low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         vector_out <= '0;
      end else begin
         vector_out <= VECTOR_BASE;
         vector_out[VECTOR_LINE_LSB +: LINE_NUM_WIDTH] <= line_num;
         vector_out[0] <= 1'b0;
      end
   end

   assign line_inhibit_mask_out = line_inhibit_mask_q;
   assign master_enable_out = master_enable_flag_q;
endmodule // priority_interrupt_module
`default_nettype wire

/* verification/prio_irq_checker.sv */
/*
 * concurrent checks on the ports of the priority interrupt block.
 * assumes daisy_priority_in_n is held low and strobes are one clk long.
 */
`timescale 1ns/1ps
`default_nettype none
// ************
// checker
// ************
module prio_irq_checker
   import prio_irq_pkg::*;
#(
   parameter int unsigned LINES = NUM_LINES,
   parameter logic [6:0] VECTOR_BASE = VECTOR_BASE_DEFAULT
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [BUS_WIDTH-1:0] bus_data_in,
   input wire logic device_address_match,
   input wire logic function_ready_pulse,
   input wire logic data_ready_pulse,
   input wire logic external_control_strobe_n,
   input wire logic irq_acknowledge_n,
   input wire logic irq_to_processor_n,
   input wire logic daisy_priority_out_n,
   input wire logic [VECTOR_WIDTH-1:0] vector_out,
   input wire logic vector_drive_enable,
   input wire logic [LINES-1:0] line_inhibit_mask_out,
   input wire logic master_enable_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // control field decode, only when this device is addressed
   logic [2:0] code;
   logic hit;
   assign code = bus_data_in[CTRL_LSB+:CTRL_WIDTH];
   assign hit = !external_control_strobe_n && device_address_match;
   chk_irq_enable: assert property (!irq_to_processor_n |-> master_enable_out)
      else $error("request without master enable");
   chk_drive_irq: assert property (vector_drive_enable |-> !irq_to_processor_n)
      else $error("vector driven without request");
   chk_drive_ack: assert property (vector_drive_enable |-> !$past(irq_acknowledge_n, 2))
      else $error("vector driven without acknowledge");
   chk_vector_form: assert property (vector_drive_enable |->
      vector_out[0] == 1'b0 && vector_out[6:4] == VECTOR_BASE[6:4])
      else $error("vector not even or off base");
   chk_vector_frozen: assert property (vector_drive_enable && $past(vector_drive_enable)
      |-> $stable(vector_out))
      else $error("vector moved during acknowledge");
   chk_mask_load: assert property ((function_ready_pulse && device_address_match)
      ##1 data_ready_pulse |=> line_inhibit_mask_out == $past(bus_data_in[LINES-1:0]))
      else $error("mask not loaded");
   chk_mask_hold: assert property (!data_ready_pulse |=> $stable(line_inhibit_mask_out))
      else $error("mask changed without load");
   chk_enable_cmd: assert property (hit && code == CTRL_ENABLE |=> master_enable_out)
      else $error("enable command ignored");
   chk_disable_cmd: assert property (hit && code == CTRL_DISABLE |=> !master_enable_out)
      else $error("disable command ignored");
   chk_bad_code: assert property (hit && (code == 3'h0 || code > 3'h5)
      |=> $stable(master_enable_out))
      else $error("reserved code acted on");
   chk_priority_pass: assert property (!daisy_priority_out_n |-> irq_to_processor_n)
      else $error("priority passed while requesting");
endmodule // prio_irq_checker
`default_nettype wire
bind priority_interrupt_module prio_irq_checker #(.LINES(LINES), .VECTOR_BASE(VECTOR_BASE))
   prio_irq_checker_i (.clk(clk), .rstn(rstn), .bus_data_in(bus_data_in),
   .device_address_match(device_address_match), .function_ready_pulse(function_ready_pulse),
   .data_ready_pulse(data_ready_pulse), .external_control_strobe_n(external_control_strobe_n),
   .irq_acknowledge_n(irq_acknowledge_n), .irq_to_processor_n(irq_to_processor_n),
   .daisy_priority_out_n(daisy_priority_out_n), .vector_out(vector_out),
   .vector_drive_enable(vector_drive_enable), .line_inhibit_mask_out(line_inhibit_mask_out),
   .master_enable_out(master_enable_out));

/* verification/proc_bus_model.sv */
/*
 * behavioural processor side: acknowledges requests, takes the vector.
 * assumes one clk domain shared with the interrupt block.
 */
`timescale 1ns/1ps
`default_nettype none
// ************
// processor model
// ************
module proc_bus_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic irq_n,
   input wire logic drv_en,
   input wire logic [6:0] vec,
   output logic ack_n,
   output logic done_p,
   output logic [6:0] vec_q,
   output logic [7:0] served
);
   int k;
   initial begin
      ack_n = 1'b1;
      done_p = 1'b0;
      vec_q = 7'h00;
      served = 8'h00;
   end
   // answer fast and slow in turn; long gap lets the pending flag settle
   always begin
      @(posedge clk);
      if (rstn && irq_n === 1'b0) begin
         repeat (served[0] ? 20 : 1) @(posedge clk);
         ack_n <= 1'b0;
         k = 0;
         while (drv_en !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
         end
         vec_q <= vec;
         @(posedge clk);
         ack_n <= 1'b1;
         done_p <= 1'b1;
         @(posedge clk);
         done_p <= 1'b0;
         served <= served + 8'h01;
         repeat (300) @(posedge clk);
      end
   end
endmodule // proc_bus_model
`default_nettype wire

/* verification/test_priority_interrupt_module.sv */
/*
 * self-checking bench for the priority interrupt block.
 * assumes the processor model answers requests; priority in held low.
 */
`timescale 1ns/1ps
`default_nettype none
// ************
// testbench
// ************
module test_priority_interrupt_module;
   import prio_irq_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, sys_rst = 1'b0, match = 1'b0, fry = 1'b0, dry = 1'b0;
   logic exc_n = 1'b1, ack_n, done_p, irq_n, prio_out_n, drv_en, men;
   logic [7:0] lines_n = 8'hFF, mask, served;
   logic [15:0] bus = 16'h0000;
   logic [6:0] vec, vec_q;
   int n_fail = 0, comparisons = 0;
   always #4 clk = ~clk;
   priority_interrupt_module priority_interrupt_module_i (.clk(clk), .rstn(rstn),
      .system_reset_signal(sys_rst), .peripheral_request_line_n(lines_n), .bus_data_in(bus),
      .device_address_match(match), .function_ready_pulse(fry), .data_ready_pulse(dry),
      .external_control_strobe_n(exc_n), .daisy_priority_in_n(1'b0), .irq_acknowledge_n(ack_n),
      .service_complete_pulse(done_p), .irq_to_processor_n(irq_n),
      .daisy_priority_out_n(prio_out_n), .vector_out(vec), .vector_drive_enable(drv_en),
      .line_inhibit_mask_out(mask), .master_enable_out(men));
   proc_bus_model proc_bus_model_i (.clk(clk), .rstn(rstn), .irq_n(irq_n), .drv_en(drv_en),
      .vec(vec), .ack_n(ack_n), .done_p(done_p), .vec_q(vec_q), .served(served));
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      if (n_fail == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // output transfer: function ready then data ready; bus inverted after release
   task bus_out(input logic [15:0] d);
      @(posedge clk) begin bus <= d; match <= 1'b1; fry <= 1'b1; end
      @(posedge clk) begin fry <= 1'b0; dry <= 1'b1; end
      @(posedge clk) begin dry <= 1'b0; match <= 1'b0; bus <= ~d; end
      @(posedge clk);
   endtask
   task ctrl(input logic [2:0] c);
      @(posedge clk) begin bus <= {7'h00, c, 6'h00}; match <= 1'b1; exc_n <= 1'b0; end
      @(posedge clk) begin exc_n <= 1'b1; match <= 1'b0; bus <= ~{7'h00, c, 6'h00}; end
      repeat (2) @(posedge clk);
   endtask
   // all-module form: no address match, bus bit 8 set
   task bcast(input logic [2:0] c);
      @(posedge clk) begin bus <= {7'h00, c, 6'h00}; exc_n <= 1'b0; end
      @(posedge clk) begin exc_n <= 1'b1; bus <= ~{7'h00, c, 6'h00}; end
      repeat (2) @(posedge clk);
   endtask
   task drop(input logic [7:0] m);
      @(posedge clk) lines_n <= lines_n & ~m;
   endtask
   task idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wait_vec(input logic [6:0] e);
      logic [7:0] c0;
      int k;
      c0 = served;
      k = 0;
      while (served === c0 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      chk(16'(k < 2000), 16'h0001);
      chk(vec_q, e);
   endtask
   task rise_all;
      @(posedge clk) lines_n <= 8'hFF;
      idle(10);
   endtask
   // mask load, refused load, system reset keeps mask
   task t_mask;
      chk(mask, 8'h00);
      bus_out(16'h00A5);
      chk(mask, 8'hA5);
      @(posedge clk) begin bus <= 16'h00FF; dry <= 1'b1; end
      @(posedge clk) begin dry <= 1'b0; bus <= 16'hFF00; end
      idle(2);
      chk(mask, 8'hA5);
      ctrl(CTRL_ENABLE);
      chk(men, 1'b1);
      @(posedge clk) sys_rst <= 1'b1;
      idle(3);
      @(posedge clk) sys_rst <= 1'b0;
      idle(5);
      chk(men, 1'b0);
      chk(mask, 8'hA5);
      bus_out(16'h0000);
   endtask
   // two lines at once: served in order, then request drops
   task t_prio;
      ctrl(CTRL_ENABLE);
      drop(8'h24);
      wait_vec(7'h44);
      wait_vec(7'h4A);
      idle(4);
      chk(irq_n, 1'b1);
      chk(prio_out_n, 1'b0);
      rise_all;
   endtask
   // masked line waits, then served once unmasked
   task t_masked;
      bus_out(16'h0002);
      drop(8'h42);
      wait_vec(7'h4C);
      idle(600);
      chk(served, 8'h03);
      bus_out(16'h0000);
      wait_vec(7'h42);
      rise_all;
   endtask
   // disabled block still captures; held-low line serves only once
   task t_disable;
      ctrl(CTRL_DISABLE);
      drop(8'h01);
      idle(400);
      chk(irq_n, 1'b1);
      ctrl(CTRL_ENABLE);
      wait_vec(7'h40);
      idle(600);
      chk(served, 8'h05);
      rise_all;
   endtask
   // clear-enable empties the capture; reserved code ignored
   task t_clear;
      ctrl(CTRL_DISABLE);
      drop(8'h08);
      idle(300);
      ctrl(CTRL_CLEAR_ENABLE);
      chk(men, 1'b1);
      idle(600);
      chk(served, 8'h05);
      ctrl(3'h6);
      chk(men, 1'b1);
      ctrl(CTRL_CLEAR);
      chk(men, 1'b1);
      bcast(3'h4);
      chk(men, 1'b0);
      bcast(3'h6);
      chk(men, 1'b1);
      ctrl(CTRL_CLEAR_DISABLE);
      chk(men, 1'b0);
      rise_all;
   endtask
   // main sequence
   initial begin
      idle(4);
      @(posedge clk) rstn <= 1'b1;
      idle(4);
      t_mask;
      t_prio;
      t_masked;
      t_disable;
      t_clear;
      wrap_up;
   end
   // watchdog well beyond the expected run of about 4000 cycles
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      wrap_up;
   end
endmodule // test_priority_interrupt_module
`default_nettype wire
